// File: include/shb_pkg.sv
// Constants and types for the SMBus host block-protocol controller
// Contract
// - Process call sends address, command, low, high; in plain mode the code skips the command byte
// - Process call reply lands in both data registers
// - Process call frame order, repeated start, no stop
// - Block payload moves through one byte register
// - Block write sends address, command, count, payload
// - Byte-done flag and interrupt after each byte
// - Block read stores count, byte, sets byte-done
// - Next read byte waits for byte-done clear
// - Last-byte bit makes final byte not-acknowledged
// - Final byte-done clear raises completion flag
// - Plain two-wire block write omits count byte
// - Block read frame order, count acked, stop
// - Two-wire read sends both data registers first
// - Two-wire read works whatever the plain mode
// - Two-wire read streams until host not-acknowledge
// - Time-out is 800 real-time clock periods
// - Unanswered slave plus time-out sets device error
package shb_pkg;
    // Register offsets on the I/O port
    localparam int               OFS_W       = 3;
    localparam logic [OFS_W-1:0] OFS_STATUS  = 3'h0;
    localparam logic [OFS_W-1:0] OFS_MODE    = 3'h1;
    localparam logic [OFS_W-1:0] OFS_CTRL    = 3'h2;
    localparam logic [OFS_W-1:0] OFS_HCMD    = 3'h3;
    localparam logic [OFS_W-1:0] OFS_TADDR   = 3'h4;
    localparam logic [OFS_W-1:0] OFS_DATA1ST = 3'h5;
    localparam logic [OFS_W-1:0] OFS_DATA2ND = 3'h6;
    localparam logic [OFS_W-1:0] OFS_BLOCK   = 3'h7;
    // Field positions
    localparam int ST_BUSY   = 0;
    localparam int ST_DONE   = 1;
    localparam int ST_DEVERR = 2;
    localparam int ST_BDONE  = 7;
    localparam int CT_PROTO  = 2;
    localparam int CT_LAST   = 5;
    localparam int CT_START  = 6;
    localparam int MD_PLAIN  = 0;
    // Protocol codes in the control register
    localparam logic [2:0] PR_PCALL = 3'h3;
    localparam logic [2:0] PR_BLOCK = 3'h5;
    localparam logic [2:0] PR_I2CRD = 3'h6;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // Eight link-clock phases per bus bit
    localparam logic [2:0] PH_SCL_UP = 3'h2;
    localparam logic [2:0] PH_MID    = 3'h4;
    localparam logic [2:0] PH_SMP    = 3'h6;
    localparam logic [2:0] PH_LAST   = 3'h7;
    localparam logic [3:0] BIT_ACK   = 4'h8;
    // Bus time-out: 25 ms, counted as 800 real-time clock periods
    localparam int         TOUT_MS      = 25;
    localparam logic [9:0] TOUT_RTC_CYC = 10'h320;
    typedef enum logic [3:0] {
        FR_IDLE, FR_START, FR_ADDRW, FR_CMD, FR_D0, FR_D1, FR_BTX,
        FR_RS, FR_ADDRR, FR_RXB, FR_WAITGO, FR_TOUT, FR_STOP, FR_FIN
    } shb_fr_t;
endpackage : shb_pkg

// File: core/shb_host.sv
// SMBus host controller: register port and block-protocol link engine
`timescale 1ns/1ps

module shb_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Foreign-domain input and its synchronised copy
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : shb_sync

module shb_host (
    // System clock and reset
    input  wire logic                      mclk,
    input  wire logic                      rst_n,
    // Link phase clock and real-time clock pin
    input  wire logic                      lclk,
    input  wire logic                      rtc_clk,
    // Register port
    input  wire logic [shb_pkg::OFS_W-1:0] io_addr,
    input  wire logic                      io_wr,
    input  wire logic                      io_rd,
    input  wire logic [7:0]                io_wdata,
    output logic      [7:0]                io_rdata,
    // Bus pins, open drain
    input  wire logic                      scl_i,
    output logic                           scl_o,
    output logic                           scl_oe_n,
    input  wire logic                      sda_i,
    output logic                           sda_o,
    output logic                           sda_oe_n,
    // Interrupt
    output logic                           system_mgmt_interrupt
);
    import shb_pkg::*;

    logic [7:0] target_address_q, host_cmd_q, block_byte_port_q;
    logic [7:0] first_data_reg_q, second_data_reg_q, status_v;
    logic [2:0] proto_q;
    logic       last_byte_q, plain_2w_q, busy_q, irq_q;
    logic       byte_done_flag_q, completion_flag_q, device_error_flag_q;
    logic       start_tg_q, go_tg_q, bd_seen_q, fin_seen_q;
    logic [1:0] ev_s;
    // Link-side state; words are loaded no later than the lclk edge that flips their toggle
    shb_fr_t    fr_q, fr_d;
    logic [2:0] ph_q;
    logic [3:0] bit_q;
    logic [8:0] rx_sh_q;
    logic [7:0] rem_q, tx_byte, lk_cnt_q, lk_lo_q, lk_hi_q, lk_blk_q;
    logic [9:0] tout_q;
    logic       rx_idx_q, nacked_q, lk_err_q, bd_tg_q, fin_tg_q;
    logic       start_seen_q, go_seen_q, rtc_prev_q;
    logic       scl_oe_n_q, sda_oe_n_q, scl_o_q, sda_o_q;
    logic [4:0] lk_s;

    // Register side, mclk
    shb_sync #(.W(2)) u_sync_m (
        .clk   (mclk),
        .rst_n (rst_n),
        .d     ({fin_tg_q, bd_tg_q}),
        .q     (ev_s)
    );

    wire logic wr_stat  = io_wr && io_addr == OFS_STATUS;
    wire logic wr_ctrl  = io_wr && io_addr == OFS_CTRL;
    wire logic wr_idle  = io_wr && !busy_q;
    wire logic bd_ev    = ev_s[0] ^ bd_seen_q;
    wire logic fin_ev   = ev_s[1] ^ fin_seen_q;
    wire logic rd_dir   = target_address_q[0];
    wire logic rx_proto = (proto_q == PR_BLOCK && rd_dir) ||
                          proto_q == PR_I2CRD;
    wire logic start_rq = wr_ctrl && io_wdata[CT_START] && !busy_q;
    wire logic clr_bd   = wr_stat && io_wdata[ST_BDONE];
    wire logic clr_dn   = wr_stat && io_wdata[ST_DONE];
    wire logic clr_er   = wr_stat && io_wdata[ST_DEVERR];
    // Hardware set wins over a software clear in the same cycle
    wire logic bd_d     = bd_ev || (byte_done_flag_q && !clr_bd);
    wire logic dn_d     = (fin_ev && !lk_err_q) ||
                          (completion_flag_q && !clr_dn);
    wire logic er_d     = (fin_ev && lk_err_q) ||
                          (device_error_flag_q && !clr_er);
    wire logic go_fire  = clr_bd && byte_done_flag_q && !bd_ev;

    always_comb begin
        status_v            = '0;
        status_v[ST_BUSY]   = busy_q;
        status_v[ST_DONE]   = completion_flag_q;
        status_v[ST_DEVERR] = device_error_flag_q;
        status_v[ST_BDONE]  = byte_done_flag_q;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q              <= 1'b0;
            byte_done_flag_q    <= 1'b0;
            completion_flag_q   <= 1'b0;
            device_error_flag_q <= 1'b0;
            irq_q               <= 1'b0;
            start_tg_q          <= 1'b0;
            go_tg_q             <= 1'b0;
            bd_seen_q           <= 1'b0;
            fin_seen_q          <= 1'b0;
        end else begin
            busy_q              <= start_rq || (busy_q && !fin_ev);
            byte_done_flag_q    <= bd_d;
            completion_flag_q   <= dn_d;
            device_error_flag_q <= er_d;
            irq_q               <= bd_d || dn_d || er_d;
            start_tg_q          <= start_tg_q ^ start_rq;
            go_tg_q             <= go_tg_q ^ go_fire;
            bd_seen_q           <= ev_s[0];
            fin_seen_q          <= ev_s[1];
        end
    end

    // Active registers are frozen while a command runs
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            target_address_q <= RST_BYTE;
            host_cmd_q       <= RST_BYTE;
            proto_q          <= '0;
            plain_2w_q       <= 1'b0;
        end else begin
            if (wr_idle && io_addr == OFS_TADDR)
                target_address_q <= io_wdata;
            if (wr_idle && io_addr == OFS_HCMD)
                host_cmd_q <= io_wdata;
            if (wr_idle && io_addr == OFS_CTRL)
                proto_q <= io_wdata[CT_PROTO +: 3];
            if (wr_idle && io_addr == OFS_MODE)
                plain_2w_q <= io_wdata[MD_PLAIN];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            last_byte_q <= 1'b0;
        end else if (start_rq) begin
            last_byte_q <= 1'b0;
        end else if (wr_ctrl) begin
            last_byte_q <= io_wdata[CT_LAST];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            first_data_reg_q  <= RST_BYTE;
            second_data_reg_q <= RST_BYTE;
            block_byte_port_q <= RST_BYTE;
        end else begin
            if (fin_ev && proto_q == PR_PCALL && !lk_err_q) begin
                first_data_reg_q  <= lk_lo_q;
                second_data_reg_q <= lk_hi_q;
            end else if (bd_ev && rx_proto && proto_q == PR_BLOCK) begin
                first_data_reg_q <= lk_cnt_q;
            end else begin
                if (wr_idle && io_addr == OFS_DATA1ST)
                    first_data_reg_q <= io_wdata;
                if (wr_idle && io_addr == OFS_DATA2ND)
                    second_data_reg_q <= io_wdata;
            end
            if (bd_ev && rx_proto)
                block_byte_port_q <= lk_blk_q;
            else if (io_wr && io_addr == OFS_BLOCK)
                block_byte_port_q <= io_wdata;
        end
    end

    wire logic [7:0] rd_mux =
        io_addr == OFS_STATUS  ? status_v :
        io_addr == OFS_MODE    ? {7'h00, plain_2w_q} :
        io_addr == OFS_CTRL    ? {2'h0, last_byte_q, proto_q, 2'h0} :
        io_addr == OFS_HCMD    ? host_cmd_q :
        io_addr == OFS_TADDR   ? target_address_q :
        io_addr == OFS_DATA1ST ? first_data_reg_q :
        io_addr == OFS_DATA2ND ? second_data_reg_q : block_byte_port_q;
    logic [7:0] io_rdata_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            io_rdata_q <= '0;
        else if (io_rd)
            io_rdata_q <= rd_mux;
    end
    assign io_rdata              = io_rdata_q;
    assign system_mgmt_interrupt = irq_q;

    // Link side, lclk; configuration is stable between the toggles
    shb_sync #(.W(5)) u_sync_l (
        .clk   (lclk),
        .rst_n (rst_n),
        .d     ({rtc_clk, sda_i, last_byte_q, go_tg_q, start_tg_q}),
        .q     (lk_s)
    );

    wire logic start_ev = lk_s[0] ^ start_seen_q;
    wire logic go_ev    = lk_s[1] ^ go_seen_q;
    wire logic last_s   = lk_s[2];
    wire logic sda_s    = lk_s[3];
    wire logic rtc_rise = lk_s[4] && !rtc_prev_q;
    wire logic is_rx    = fr_q == FR_RXB;
    wire logic is_byte  = fr_q inside {FR_ADDRW, FR_CMD, FR_D0, FR_D1,
                                       FR_BTX, FR_ADDRR, FR_RXB};
    wire logic is_strt  = fr_q == FR_START || fr_q == FR_RS;
    wire logic is_stop  = fr_q == FR_STOP;
    wire logic on_bus   = is_byte || is_strt || is_stop;
    wire logic eng_done = on_bus && ph_q == PH_LAST &&
                          (!is_byte || bit_q == BIT_ACK);
    wire logic slv_nack = !is_rx && rx_sh_q[0];
    wire logic pcall    = proto_q == PR_PCALL;
    wire logic blk_rd   = proto_q == PR_BLOCK && target_address_q[0];
    wire logic blk_wr   = proto_q == PR_BLOCK && !target_address_q[0];
    wire logic skip_cmd = pcall && plain_2w_q;
    // Host acknowledge: 1 releases the line, a not-acknowledge
    wire logic host_nack = pcall ? rx_idx_q :
        (last_s && (rx_idx_q || proto_q == PR_I2CRD));
    wire logic bit_val  = bit_q == BIT_ACK ? (!is_rx || host_nack) :
                          tx_byte[~bit_q[2:0]];
    wire logic hold_low = fr_q == FR_WAITGO || fr_q == FR_TOUT;
    wire logic scl_lo_d =
        is_byte ? (ph_q < PH_SCL_UP || ph_q >= PH_SMP) :
        is_strt ? (ph_q >= PH_SMP ||
                   (fr_q == FR_RS && ph_q < PH_SCL_UP)) :
        is_stop ? ph_q < PH_SCL_UP : hold_low;
    wire logic sda_lo_d = is_byte ? !bit_val :
        is_strt ? ph_q >= PH_MID :
        is_stop ? ph_q < PH_MID : hold_low;
    wire shb_fr_t after_cmd = blk_rd ? FR_RS :
        blk_wr ? (plain_2w_q ? FR_BTX : FR_D0) : FR_D0;

    always_comb begin
        unique case (fr_q)
            FR_ADDRW: tx_byte = {target_address_q[7:1], 1'b0};
            FR_ADDRR: tx_byte = {target_address_q[7:1], 1'b1};
            FR_CMD:   tx_byte = host_cmd_q;
            FR_D0:    tx_byte = first_data_reg_q;
            FR_D1:    tx_byte = second_data_reg_q;
            FR_BTX:   tx_byte = block_byte_port_q;
            default:  tx_byte = 8'hFF;
        endcase
    end

    always_comb begin
        fr_d = fr_q;
        unique case (fr_q)
            FR_IDLE:   if (start_ev) fr_d = FR_START;
            FR_START:  if (eng_done) fr_d = FR_ADDRW;
            FR_ADDRW:  if (eng_done) fr_d = slv_nack ? FR_TOUT :
                                           skip_cmd ? FR_D0 : FR_CMD;
            FR_CMD:    if (eng_done) fr_d = slv_nack ? FR_TOUT : after_cmd;
            FR_D0:     if (eng_done) fr_d = slv_nack ? FR_TOUT :
                                           blk_wr ? FR_BTX : FR_D1;
            FR_D1:     if (eng_done) fr_d = slv_nack ? FR_TOUT : FR_RS;
            FR_BTX:    if (eng_done) fr_d = slv_nack ? FR_TOUT : FR_WAITGO;
            FR_RS:     if (eng_done) fr_d = FR_ADDRR;
            FR_ADDRR:  if (eng_done) fr_d = slv_nack ? FR_TOUT : FR_RXB;
            FR_RXB:    if (eng_done) fr_d = pcall ?
                           (rx_idx_q ? FR_STOP : FR_RXB) :
                           (blk_rd && !rx_idx_q ? FR_RXB : FR_WAITGO);
            FR_WAITGO: if (go_ev) fr_d = blk_wr ?
                           (rem_q == 8'h00 ? FR_STOP : FR_BTX) :
                           (nacked_q ? FR_STOP : FR_RXB);
            FR_TOUT:   if (tout_q == TOUT_RTC_CYC) fr_d = FR_STOP;
            FR_STOP:   if (eng_done) fr_d = FR_FIN;
            FR_FIN:    fr_d = FR_IDLE;
        endcase
    end

    always_ff @(posedge lclk or negedge rst_n) begin
        if (!rst_n) begin
            fr_q         <= FR_IDLE;
            ph_q         <= '0;
            bit_q        <= '0;
            rx_sh_q      <= '0;
            start_seen_q <= 1'b0;
            go_seen_q    <= 1'b0;
            rtc_prev_q   <= 1'b0;
        end else begin
            fr_q         <= fr_d;
            ph_q         <= on_bus ? ph_q + 3'h1 : 3'h0;
            start_seen_q <= lk_s[0];
            go_seen_q    <= lk_s[1];
            rtc_prev_q   <= lk_s[4];
            if (!on_bus || eng_done)
                bit_q <= '0;
            else if (ph_q == PH_LAST)
                bit_q <= bit_q + 4'h1;
            if (is_byte && ph_q == PH_SMP)
                rx_sh_q <= {rx_sh_q[7:0], sda_s};
        end
    end

    always_ff @(posedge lclk or negedge rst_n) begin
        if (!rst_n) begin
            rem_q    <= '0;
            rx_idx_q <= 1'b0;
            nacked_q <= 1'b0;
            tout_q   <= '0;
            lk_err_q <= 1'b0;
        end else begin
            if (start_ev && fr_q == FR_IDLE) begin
                rem_q    <= first_data_reg_q;
                rx_idx_q <= 1'b0;
                nacked_q <= 1'b0;
                lk_err_q <= 1'b0;
            end
            if (fr_q == FR_BTX && eng_done)
                rem_q <= rem_q - 8'h01;
            if (is_rx && eng_done) begin
                rx_idx_q <= 1'b1;
                nacked_q <= host_nack;
            end
            tout_q <= fr_q != FR_TOUT ? 10'h000 :
                      tout_q + {9'h000, rtc_rise};
            if (fr_q == FR_TOUT && fr_d == FR_STOP)
                lk_err_q <= 1'b1;
        end
    end

    always_ff @(posedge lclk or negedge rst_n) begin
        if (!rst_n) begin
            lk_cnt_q <= '0;
            lk_lo_q  <= '0;
            lk_hi_q  <= '0;
            lk_blk_q <= '0;
            bd_tg_q  <= 1'b0;
            fin_tg_q <= 1'b0;
        end else begin
            if (is_rx && eng_done && pcall && !rx_idx_q)
                lk_lo_q <= rx_sh_q[8:1];
            if (is_rx && eng_done && pcall && rx_idx_q)
                lk_hi_q <= rx_sh_q[8:1];
            if (is_rx && eng_done && blk_rd && !rx_idx_q)
                lk_cnt_q <= rx_sh_q[8:1];
            if (is_rx && eng_done && fr_d == FR_WAITGO)
                lk_blk_q <= rx_sh_q[8:1];
            if (fr_d == FR_WAITGO && fr_q != FR_WAITGO)
                bd_tg_q <= !bd_tg_q;
            if (fr_q == FR_FIN)
                fin_tg_q <= !fin_tg_q;
        end
    end

    // Pins are registered; they lag the phase decode by one lclk
    always_ff @(posedge lclk or negedge rst_n) begin
        if (!rst_n) begin
            scl_oe_n_q <= 1'b1;
            sda_oe_n_q <= 1'b1;
            scl_o_q    <= 1'b0;
            sda_o_q    <= 1'b0;
        end else begin
            scl_oe_n_q <= !scl_lo_d;
            sda_oe_n_q <= !sda_lo_d;
            scl_o_q    <= 1'b0;
            sda_o_q    <= 1'b0;
        end
    end
    assign scl_oe_n = scl_oe_n_q;
    assign sda_oe_n = sda_oe_n_q;
    assign scl_o    = scl_o_q;
    assign sda_o    = sda_o_q;

    property p_bd_set;
        @(posedge mclk) disable iff (!rst_n)
        bd_ev |=> byte_done_flag_q && system_mgmt_interrupt;
    endproperty
    a_bd_set: assert property (p_bd_set)
        else $error("byte-done not set");
    property p_blk_load;
        @(posedge mclk) disable iff (!rst_n)
        bd_ev && rx_proto |=> block_byte_port_q == $past(lk_blk_q);
    endproperty
    a_blk_load: assert property (p_blk_load)
        else $error("rx byte lost");
    property p_done;
        @(posedge mclk) disable iff (!rst_n)
        fin_ev && !lk_err_q |=> completion_flag_q && !busy_q;
    endproperty
    a_done: assert property (p_done)
        else $error("no completion");
    property p_pcall_ret;
        @(posedge mclk) disable iff (!rst_n)
        fin_ev && pcall && !lk_err_q |=> first_data_reg_q ==
            $past(lk_lo_q) && second_data_reg_q == $past(lk_hi_q);
    endproperty
    a_pcall_ret: assert property (p_pcall_ret)
        else $error("reply lost");
    property p_go;
        @(posedge mclk) disable iff (!rst_n)
        $changed(go_tg_q) |-> $past(byte_done_flag_q) && !byte_done_flag_q;
    endproperty
    a_go: assert property (p_go)
        else $error("go without clear");
    property p_order;
        @(posedge lclk) disable iff (!rst_n)
        fr_q == FR_D1 && eng_done && !slv_nack |=> fr_q == FR_RS [*8];
    endproperty
    a_order: assert property (p_order)
        else $error("no repeated start");
    property p_nocnt;
        @(posedge lclk) disable iff (!rst_n)
        fr_q == FR_CMD && eng_done && !slv_nack && blk_wr && plain_2w_q
            |=> fr_q == FR_BTX;
    endproperty
    a_nocnt: assert property (p_nocnt)
        else $error("count not skipped");
    property p_msb;
        @(posedge lclk) disable iff (!rst_n)
        fr_q == FR_ADDRW && bit_q == 4'h0 && ph_q == PH_SMP
            |-> sda_oe_n_q == target_address_q[7];
    endproperty
    a_msb: assert property (p_msb)
        else $error("address not MSB first");
    property p_tout;
        @(posedge lclk) disable iff (!rst_n)
        fr_q == FR_TOUT && tout_q == TOUT_RTC_CYC
            |=> fr_q == FR_STOP && lk_err_q;
    endproperty
    a_tout: assert property (p_tout)
        else $error("time-out missed");
endmodule : shb_host

// File: tb/shb_slave_model.sv
// Behavioural two-wire slave: logs written bytes, replies from a table
`timescale 1ns/1ps
module shb_slave_model (
    // Bus wires
    input  wire logic scl,
    input  wire logic sda,
    output logic      sda_pull_n,
    // Bench control
    input  wire logic refuse
);
    logic [7:0] sh, tx[0:3], rx_q[$];
    logic [3:0] n;
    logic       rd, first, nack;
    int         idx;
    initial begin
        sda_pull_n = 1'b1;
        n = 4'h0;
        rd = 1'b0;
    end
    always @(negedge sda) if (scl) begin
        n = 4'h0;
        first = 1'b1;
        rd = 1'b0;
        nack = 1'b0;
        idx = 0;
    end
    always @(posedge scl) begin
        if (n < 8) sh = {sh[6:0], sda};
        else if (rd) nack = sda;
        n = n + 4'h1;
    end
    // Data only moves while the clock is low, so it never mimics a start
    always @(negedge scl) begin
        if (n == 8 && !rd) begin
            rx_q.push_back(sh);
            if (first) rd = sh[0];
            sda_pull_n = refuse;
        end else if (n == 9) begin
            n = 4'h0;
            if (rd && !nack && !first) idx++;
            sda_pull_n = (rd && !nack) ? tx[idx][7] : 1'b1;
            first = 1'b0;
        end else begin
            sda_pull_n = (!rd || n > 7 || nack) ? 1'b1 : tx[idx][7-n];
        end
    end
endmodule : shb_slave_model

// File: tb/tb_top.sv
// Self-checking bench for the SMBus host block-protocol controller
`timescale 1ns/1ps
module tb_top;
    import shb_pkg::*;
    logic mclk = 0, rst_n = 0, lclk = 0, rtc_clk = 0, io_wr = 0, io_rd = 0;
    logic [OFS_W-1:0] io_addr = '0;
    logic [7:0] io_wdata = '0, io_rdata, st;
    logic scl_o, scl_oe_n, sda_o, sda_oe_n, smi, pull_n, refuse = 0;
    wire  scl_w = scl_oe_n ? 1'b1 : scl_o;
    wire  sda_w = (sda_oe_n ? 1'b1 : sda_o) & pull_n;
    int   mismatches = 0, n_tests = 0;
    time  t0;
    logic [OFS_W-1:0] r_a[5] = '{OFS_HCMD, OFS_TADDR, OFS_DATA1ST,
                                 OFS_DATA2ND, OFS_BLOCK};
    logic [7:0]       r_d[5] = '{8'h5A, 8'hA4, 8'h3C, 8'hC3, 8'h81};
    always #10 mclk = ~mclk;
    always #24 lclk = ~lclk;
    always #100 rtc_clk = ~rtc_clk;
    shb_host shb_host_inst (.mclk(mclk), .rst_n(rst_n), .lclk(lclk),
        .rtc_clk(rtc_clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .scl_i(scl_w),
        .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .system_mgmt_interrupt(smi));
    shb_slave_model shb_slave_model_inst (.scl(scl_w), .sda(sda_w),
        .sda_pull_n(pull_n), .refuse(refuse));
    task automatic wrap_up;
        $display("mismatches %0d n_tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    task automatic chk8(input string nm, input logic [7:0] e, g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk8
    task automatic wr(input logic [OFS_W-1:0] a, input logic [7:0] d);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge mclk);
        io_wr <= 1'b0;
        @(posedge mclk);
    endtask : wr
    // Read data is registered, so it is taken one edge after the strobe
    task automatic rd(input logic [OFS_W-1:0] a);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge mclk);
        io_rd <= 1'b0;
        @(posedge mclk);
        st = io_rdata;
    endtask : rd
    task automatic chk_reg(input logic [OFS_W-1:0] a, input logic [7:0] e);
        rd(a);
        chk8("register", e, st);
    endtask : chk_reg
    task automatic wait_st(input int b);
        for (int i = 0; i < 20000; i++) begin
            rd(OFS_STATUS);
            if (st[b] === 1'b1) return;
        end
        mismatches++;
        wrap_up();
    endtask : wait_st
    task automatic chk_q(input logic [7:0] e[$]);
        chk8("count", 8'(e.size()), 8'(shb_slave_model_inst.rx_q.size()));
        foreach (e[i]) chk8("bus byte", e[i], shb_slave_model_inst.rx_q[i]);
        shb_slave_model_inst.rx_q.delete();
    endtask : chk_q
    task automatic setup(input logic [7:0] a, c, d0, d1, p);
        wr(OFS_TADDR, a);
        wr(OFS_HCMD, c);
        wr(OFS_DATA1ST, d0);
        wr(OFS_DATA2ND, d1);
        wr(OFS_CTRL, 8'h40 | {3'h0, p[2:0], 2'h0});
    endtask : setup
    task automatic fin;
        wait_st(ST_DONE);
        wr(OFS_STATUS, 8'h02);
        chk8("interrupt", 8'h00, {7'h0, smi});
        chk8("pins", 8'h00, {6'h0, scl_o, sda_o});
    endtask : fin
    task automatic xfer(input logic [7:0] e[$], input logic rx);
        foreach (e[i]) begin
            wait_st(ST_BDONE);
            chk8("interrupt", 8'h01, {7'h0, smi});
            if (rx) chk_reg(OFS_BLOCK, e[i]);
            if (rx && i == e.size() - 2) wr(OFS_CTRL, 8'h20);
            if (!rx && i < e.size() - 1) wr(OFS_BLOCK, e[i+1]);
            wr(OFS_STATUS, 8'h80);
        end
        fin();
    endtask : xfer
    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        chk_reg(OFS_TADDR, RST_BYTE);
        for (int i = 0; i < 5; i++) begin
            wr(r_a[i], r_d[i]);
            chk_reg(r_a[i], r_d[i]);
        end
        shb_slave_model_inst.tx = '{8'h78, 8'h56, 8'h00, 8'h00};
        setup(8'hA0, 8'h11, 8'h34, 8'h12, PR_PCALL);
        fin();
        chk_q({8'hA0, 8'h11, 8'h34, 8'h12, 8'hA1});
        chk_reg(OFS_DATA1ST, 8'h78);
        chk_reg(OFS_DATA2ND, 8'h56);
        wr(OFS_BLOCK, 8'hC1);
        setup(8'hA0, 8'h22, 8'h02, 8'h00, PR_BLOCK);
        xfer({8'hC1, 8'hC2}, 1'b0);
        chk_q({8'hA0, 8'h22, 8'h02, 8'hC1, 8'hC2});
        wr(OFS_MODE, 8'h01);
        wr(OFS_BLOCK, 8'hC3);
        setup(8'hA0, 8'h33, 8'h01, 8'h00, PR_BLOCK);
        xfer({8'hC3}, 1'b0);
        chk_q({8'hA0, 8'h33, 8'hC3});
        shb_slave_model_inst.tx = '{8'h11, 8'h22, 8'h00, 8'h00};
        setup(8'hA0, 8'h44, 8'h55, 8'h66, PR_I2CRD);
        xfer({8'h11, 8'h22}, 1'b1);
        chk_q({8'hA0, 8'h44, 8'h55, 8'h66, 8'hA1});
        wr(OFS_MODE, 8'h00);
        shb_slave_model_inst.tx = '{8'h02, 8'h9A, 8'hBC, 8'h00};
        setup(8'hA1, 8'h55, 8'h00, 8'h00, PR_BLOCK);
        xfer({8'h9A, 8'hBC}, 1'b1);
        chk_reg(OFS_DATA1ST, 8'h02);
        chk_q({8'hA0, 8'h55, 8'hA1});
        chk8("nack", 8'h01, {7'h0, shb_slave_model_inst.nack});
        refuse <= 1'b1;
        t0 = $time;
        setup(8'hA0, 8'h11, 8'h00, 8'h00, PR_PCALL);
        wait_st(ST_DEVERR);
        chk8("no completion", 8'h00, st & 8'h02);
        chk8("wait", 8'h01, 8'($time - t0 inside {[160000:175000]}));
        // Reset in mid-frame: flags clear and both lines are let go
        refuse <= 1'b0;
        setup(8'hA0, 8'h11, 8'h00, 8'h00, PR_PCALL);
        repeat (100) @(posedge mclk);
        rst_n <= 1'b0;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        chk_reg(OFS_STATUS, 8'h00);
        chk8("released", 8'h03, {6'h0, scl_oe_n, sda_oe_n});
        wrap_up();
    end
endmodule : tb_top
